/* File: hw/lswitch_pkg.sv */
// Constants, states and register map of the load switch sequencer
package lswitch_pkg;

   // Clock and interval figures
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned DEBOUNCE_US   = 50000;
   localparam int unsigned BBM_US        = 50000;
   localparam int unsigned SOFT_START_US = 800;
   localparam int unsigned LDELAY_US     = 200;

   // Least times round up, the longest time rounds down
   localparam int unsigned DEBOUNCE_CYC = 32'((64'(DEBOUNCE_US) *
      64'd1000000 + 64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS));
   localparam int unsigned BBM_CYC = 32'((64'(BBM_US) * 64'd1000000 +
      64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS));
   localparam int unsigned SOFT_CYC = 32'((64'(SOFT_START_US) *
      64'd1000000 + 64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS));
   localparam int unsigned LDELAY_CYC = 32'((64'(LDELAY_US) *
      64'd1000000) / 64'(CLK_PERIOD_PS));

   // Timer width
   localparam int unsigned TIMER_W = 24;

   // Register map, byte addresses
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;

   // Control fields and reset value
   localparam int unsigned CTRL_MODE_BIT = 0;
   localparam int unsigned CTRL_HOLD_BIT = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h0;

   // Status fields
   localparam int unsigned ST_STATE_LSB  = 0;
   localparam int unsigned ST_OTG_BIT    = 3;
   localparam int unsigned ST_INOK_BIT   = 4;
   localparam int unsigned ST_OUTOK_BIT  = 5;
   localparam int unsigned ST_FAULT_BIT  = 6;
   localparam int unsigned ST_AVAIL_BIT  = 7;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h0,
      ST_LDELAY  = 3'h1,
      ST_BBM     = 3'h2,
      ST_SOFT    = 3'h3,
      ST_ON      = 3'h4,
      ST_FAULT   = 3'h5
   } seq_state_e;

endpackage

/* File: hw/interval_timer.sv */
// Restartable interval counter that flags expiry
`timescale 1ns/1ps
module interval_timer #(
   parameter int unsigned W = 24
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Control
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   // Result
   output logic              done_q
);

   logic [W-1:0] count_q;

   // Counts while run holds, restarts from zero when it drops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_q <= '0;
         done_q  <= 1'b0;
      end else if (!run) begin
         count_q <= '0;
         done_q  <= 1'b0;
      end else begin
         if (count_q != limit) begin
            count_q <= count_q + W'(1);
         end
         done_q <= (count_q >= limit - W'(1));
      end
   end

endmodule

/* File: hw/dual_input_load_switch_sequencer.sv */
// Sequencer of a two-input bidirectional power load switch
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module dual_input_load_switch_sequencer
   import lswitch_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = lswitch_pkg::DEBOUNCE_CYC,
   parameter int unsigned BBM_CYCLES      = lswitch_pkg::BBM_CYC,
   parameter int unsigned SOFT_CYCLES     = lswitch_pkg::SOFT_CYC,
   parameter int unsigned LDELAY_CYCLES   = lswitch_pkg::LDELAY_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog comparator results
   input  wire logic        wired_power_input_ok,
   input  wire logic        ovp_high_trip,
   input  wire logic        ovp_low_trip,
   input  wire logic        output_ok,
   input  wire logic        over_temp,
   // Logic pins
   input  wire logic        overvoltage_threshold_select,
   input  wire logic        switch_enable_n,
   input  wire logic        flag_in,
   output logic             flag_out,
   output logic             flag_oe_n,
   input  wire logic        receiver_dc_enable_in,
   output logic             receiver_dc_enable_out,
   output logic             receiver_dc_enable_oe_n,
   output logic             charger_good_output_out,
   output logic             charger_good_output_oe_n,
   // Power stage controls
   output logic             switch_forward,
   output logic             switch_otg,
   output logic             soft_start_ramp,
   output logic             output_discharge,
   output logic             fault
);

   // Refuse counts that the timers cannot hold
   if (DEBOUNCE_CYCLES == 0 || BBM_CYCLES == 0 || SOFT_CYCLES == 0 ||
       LDELAY_CYCLES == 0 || DEBOUNCE_CYCLES >= (1 << TIMER_W) ||
       BBM_CYCLES >= (1 << TIMER_W) || SOFT_CYCLES >= (1 << TIMER_W) ||
       LDELAY_CYCLES >= (1 << TIMER_W)) begin : g_bad_count
      $error("interval counts must lie between 1 and timer range");
   end

   localparam int unsigned NSYNC = 9;

   // Pin synchronisers and filtered levels
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [NSYNC-1:0] sync3_q;
   logic [NSYNC-1:0] pin_q;
   wire  [NSYNC-1:0] pin_raw;

   // Sequencer state and control registers
   seq_state_e  state_q;
   seq_state_e  state_d;
   logic        dir_otg_q;
   logic        dir_otg_d;
   logic [1:0]  ctrl_q;
   logic        flag_armed_q;

   // Output registers
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        flag_oe_n_q;
   logic        rx_oe_n_q;
   logic        chg_oe_n_q;
   logic        fwd_q;
   logic        otg_q;
   logic        soft_q;
   logic        dis_q;
   logic        fault_q;

   // Timer results
   logic        deb_done;
   logic        bbm_done;
   logic        soft_done;
   logic        ld_done;

   assign pin_raw = {over_temp, output_ok, ovp_low_trip, ovp_high_trip,
                     wired_power_input_ok, overvoltage_threshold_select,
                     switch_enable_n, flag_in, receiver_dc_enable_in};

   // Three-stage synchronisers; a level counts once stages two and
   // three agree
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         pin_q   <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q   <= (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
      end
   end

   // Named filtered levels
   wire rx_hi_s   = pin_q[0];
   wire flag_hi_s = pin_q[1];
   wire en_n_s    = pin_q[2];
   wire vsel_s    = pin_q[3];
   wire in_ok_s   = pin_q[4];
   wire ovph_s    = pin_q[5];
   wire ovpl_s    = pin_q[6];
   wire out_ok_s  = pin_q[7];
   wire ot_s      = pin_q[8];

   // Mode and software hold
   wire auto_mode = ctrl_q[CTRL_MODE_BIT];
   wire hold_off  = ctrl_q[CTRL_HOLD_BIT];

   // Threshold select grounded picks the higher trip point
   wire ovp_s    = vsel_s ? ovpl_s : ovph_s;
   wire fault_w  = ovp_s | ot_s;

   // Input validity: debounced, output side taken directly
   wire in_ok     = deb_done;
   wire otg_avail = !in_ok_s && out_ok_s;

   // Forward request: system enable in slave, input alone in
   // autonomous mode
   wire fwd_req = !hold_off && in_ok &&
                  (auto_mode || !en_n_s);

   // OTG request: enable low in slave, flag pulled low in autonomous
   wire otg_slave = !auto_mode && !en_n_s && otg_avail;
   wire otg_auto  = auto_mode && otg_avail && flag_armed_q &&
                    !flag_hi_s;
   wire otg_req   = !hold_off && (otg_slave || otg_auto);

   // Request of the direction in progress
   wire cur_req = dir_otg_q ? otg_req : fwd_req;

   // Break-before-make counts only while the receiver line is high
   wire bbm_run = (state_q == ST_BBM) && rx_hi_s;

   // Interval timers
   interval_timer #(.W(TIMER_W)) u_debounce (
      .clk    (clk),
      .reset  (reset),
      .run    (in_ok_s && !ovp_s),
      .limit  (TIMER_W'(DEBOUNCE_CYCLES)),
      .done_q (deb_done)
   );

   interval_timer #(.W(TIMER_W)) u_bbm (
      .clk    (clk),
      .reset  (reset),
      .run    (bbm_run),
      .limit  (TIMER_W'(BBM_CYCLES)),
      .done_q (bbm_done)
   );

   interval_timer #(.W(TIMER_W)) u_soft (
      .clk    (clk),
      .reset  (reset),
      .run    (state_q == ST_SOFT),
      .limit  (TIMER_W'(SOFT_CYCLES)),
      .done_q (soft_done)
   );

   interval_timer #(.W(TIMER_W)) u_ldelay (
      .clk    (clk),
      .reset  (reset),
      .run    (state_q == ST_LDELAY),
      .limit  (TIMER_W'(LDELAY_CYCLES)),
      .done_q (ld_done)
   );

   // Next state of the sequencer
   always_comb begin
      state_d   = state_q;
      dir_otg_d = dir_otg_q;
      case (state_q)
         ST_STANDBY: begin
            if (fwd_req) begin
               dir_otg_d = 1'b0;
               if (auto_mode) begin
                  state_d = ST_BBM;
               end else begin
                  state_d = ST_LDELAY;
               end
            end else if (otg_req) begin
               dir_otg_d = 1'b1;
               state_d   = ST_LDELAY;
            end
         end
         ST_LDELAY: begin
            if (!cur_req) begin
               state_d = ST_STANDBY;
            end else if (ld_done) begin
               state_d = ST_SOFT;
            end
         end
         ST_BBM: begin
            if (!cur_req) begin
               state_d = ST_STANDBY;
            end else if (bbm_done) begin
               state_d = ST_SOFT;
            end
         end
         ST_SOFT: begin
            if (!cur_req) begin
               state_d = ST_STANDBY;
            end else if (soft_done) begin
               state_d = ST_ON;
            end
         end
         ST_ON: begin
            if (!cur_req) begin
               state_d = ST_STANDBY;
            end
         end
         ST_FAULT: begin
            if (!fault_w) begin
               state_d = ST_STANDBY;
            end
         end
         default: begin
            state_d = ST_STANDBY;
         end
      endcase
      if (fault_w) begin
         state_d = ST_FAULT;
      end
   end

   // State and direction registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q   <= ST_STANDBY;
         dir_otg_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         dir_otg_q <= dir_otg_d;
      end
   end

   // In autonomous mode the flag pull-down is released only when OTG may start; the low
   // level is accepted only after the pin has been seen high
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag_armed_q <= 1'b0;
      end else if (!auto_mode || !otg_avail || fault_w) begin
         flag_armed_q <= 1'b0;
      end else if (flag_oe_n_q && flag_hi_s) begin
         flag_armed_q <= 1'b1;
      end
   end

   // Conduction state decoded from the sequencer
   wire conducting = (state_q == ST_SOFT) || (state_q == ST_ON);

   // Power stage and pin drivers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fwd_q       <= 1'b0;
         otg_q       <= 1'b0;
         soft_q      <= 1'b0;
         dis_q       <= 1'b0;
         fault_q     <= 1'b0;
         flag_oe_n_q <= 1'b1;
         rx_oe_n_q   <= 1'b1;
         chg_oe_n_q  <= 1'b1;
      end else begin
         fwd_q       <= conducting && !dir_otg_q;
         otg_q       <= conducting && dir_otg_q;
         soft_q      <= (state_q == ST_SOFT) && !soft_done;
         dis_q       <= (state_q == ST_BBM);
         fault_q     <= (state_q == ST_FAULT);
         flag_oe_n_q <= !(auto_mode && !otg_avail);
         rx_oe_n_q   <= !(auto_mode && !in_ok);
         chg_oe_n_q  <= !in_ok;
      end
   end

   // APB decode
   wire apb_access = psel && penable;
   wire addr_ctrl  = (paddr == CTRL_ADDR);
   wire addr_stat  = (paddr == STATUS_ADDR);
   wire addr_ok    = addr_ctrl || addr_stat;
   wire apb_take   = apb_access && pready_q;

   // Status word from live block state
   wire [31:0] status_w = {24'h0, otg_avail, fault_q, out_ok_s, in_ok,
                           dir_otg_q, state_q};
   wire [31:0] rd_w     = addr_ctrl ? {30'h0, ctrl_q} :
                          addr_stat ? status_w : 32'h0;

   // APB answer: pready one cycle into the access phase
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= apb_access && !pready_q;
         pslverr_q <= apb_access && !pready_q && !addr_ok;
         prdata_q  <= (apb_access && !pready_q && !pwrite) ? rd_w : 32'h0;
      end
   end

   // Control register write at the completing edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= CTRL_RESET;
      end else if (apb_take && pwrite && addr_ctrl) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // Output port wiring, each from a flip-flop except the three pin data outputs, which are tied low
   assign prdata                   = prdata_q;
   assign pready                   = pready_q;
   assign pslverr                  = pslverr_q;
   assign flag_out                 = 1'b0;
   assign flag_oe_n                = flag_oe_n_q;
   assign receiver_dc_enable_out   = 1'b0;
   assign receiver_dc_enable_oe_n  = rx_oe_n_q;
   assign charger_good_output_out  = 1'b0;
   assign charger_good_output_oe_n = chg_oe_n_q;
   assign switch_forward           = fwd_q;
   assign switch_otg               = otg_q;
   assign soft_start_ramp          = soft_q;
   assign output_discharge         = dis_q;
   assign fault                    = fault_q;

endmodule

/* File: test/sys_partner.sv */
// System-side model: drives enable, flag and receiver lines
`timescale 1ns/1ps
module sys_partner (
   // Clock and bench commands
   input  wire logic clk,
   input  wire logic slave,
   input  wire logic en_req,
   input  wire logic otg_req,
   // Device open-drain enables
   input  wire logic flag_oe_n,
   input  wire logic rx_oe_n,
   // Resolved pin levels
   output logic      switch_enable_n,
   output logic      flag_in,
   output logic      receiver_dc_enable_in
);
   logic flag_pull_q;
   logic rx_pull_q;
   // Pins change just after the edge
   always @(posedge clk) begin
      switch_enable_n <= slave ? !en_req : 1'b0;
      flag_pull_q <= slave | otg_req;
      rx_pull_q <= slave;
   end
   // Open-drain lines with pull-ups
   assign flag_in = !(flag_pull_q | !flag_oe_n);
   assign receiver_dc_enable_in = !(rx_pull_q | !rx_oe_n);
endmodule

/* File: test/lswitch_chk.sv */
// Port assertions of the load switch sequencer
`timescale 1ns/1ps
module lswitch_chk #(
   parameter int unsigned SOFT_CYCLES = 10
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Sensed levels
   input wire logic        wired_power_input_ok,
   input wire logic        output_ok,
   // Power stage
   input wire logic        switch_forward,
   input wire logic        switch_otg,
   input wire logic        soft_start_ramp,
   input wire logic        output_discharge,
   input wire logic        fault
);
   logic [23:0] soft_q;
   logic [23:0] soft_d;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles the ramp has run so far
   assign soft_d = soft_start_ramp ? soft_q + 24'h1 : 24'h0;
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         soft_q <= 24'h0;
      else
         soft_q <= soft_d;
   end
   // APB phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   a_apb_answer_time: assert property (s_setup ##1 s_access |=> pready)
      else $error("pready not one cycle after access");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_reads_zero: assert property (pslverr |-> pready && prdata == 0)
      else $error("error response malformed");
   a_fault_cuts_switch: assert property ($rose(fault) |->
      ##[1:2] !switch_forward && !switch_otg)
      else $error("switch not off after fault");
   a_fault_holds_off: assert property (fault [*3] |->
      !switch_forward && !switch_otg)
      else $error("switch on during fault");
   a_one_direction: assert property (!(switch_forward && switch_otg))
      else $error("both directions on");
   a_ramp_at_start: assert property ($rose(switch_forward) ||
      $rose(switch_otg) |-> soft_start_ramp)
      else $error("switch on without soft-start");
   a_ramp_length: assert property ($fell(soft_start_ramp) &&
      (switch_forward || switch_otg) |-> soft_q >= SOFT_CYCLES)
      else $error("soft-start too short");
   a_discharge_off: assert property (output_discharge |->
      !switch_forward && !switch_otg)
      else $error("discharge while conducting");
   a_otg_needs_out: assert property ($rose(switch_otg) |->
      $past(output_ok, 5) && !$past(wired_power_input_ok, 5))
      else $error("reverse conduction without conditions");
endmodule

bind dual_input_load_switch_sequencer lswitch_chk #(
   .SOFT_CYCLES(SOFT_CYCLES)
) u_chk (
   .clk, .reset, .psel, .penable, .prdata, .pready, .pslverr,
   .wired_power_input_ok, .output_ok, .switch_forward, .switch_otg,
   .soft_start_ramp, .output_discharge, .fault
);

/* File: test/dual_input_load_switch_sequencer_tb_top.sv */
// Self-checking bench of the load switch sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   bad_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
   end end
module dual_input_load_switch_sequencer_tb_top;
   import lswitch_pkg::*;
   localparam int unsigned DEB = 20;
   localparam int unsigned BBM = 20;
   localparam int unsigned SOFT = 10;
   localparam int unsigned LD = 5;
   localparam logic [3:0] FT [5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h8};
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, wv;
   wire  [2:0]  od;
   logic        wired_power_input_ok, ovp_high_trip, ovp_low_trip;
   logic        output_ok, over_temp, overvoltage_threshold_select;
   logic        switch_enable_n, flag_in, flag_oe_n, receiver_dc_enable_in;
   logic        receiver_dc_enable_oe_n, charger_good_output_oe_n;
   logic        switch_forward, switch_otg, soft_start_ramp;
   logic        output_discharge, fault, slave, en_req, otg_req, disc_seen;
   int          bad_count, cmp_count, seed, n, run, last_soft;

   dual_input_load_switch_sequencer #(
      .DEBOUNCE_CYCLES(DEB), .BBM_CYCLES(BBM),
      .SOFT_CYCLES(SOFT), .LDELAY_CYCLES(LD)
   ) u_dut (
      .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .wired_power_input_ok, .ovp_high_trip,
      .ovp_low_trip, .output_ok, .over_temp,
      .overvoltage_threshold_select, .switch_enable_n, .flag_in,
      .flag_out(od[2]), .flag_oe_n, .receiver_dc_enable_in,
      .receiver_dc_enable_out(od[1]), .receiver_dc_enable_oe_n,
      .charger_good_output_out(od[0]), .charger_good_output_oe_n,
      .switch_forward, .switch_otg, .soft_start_ramp, .output_discharge,
      .fault
   );
   sys_partner u_sys (
      .clk, .slave, .en_req, .otg_req, .flag_oe_n,
      .rx_oe_n(receiver_dc_enable_oe_n), .switch_enable_n, .flag_in,
      .receiver_dc_enable_in
   );

   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #50000;
      bad_count++;
      finish_test();
   end
   // Watches discharge and ramp length
   always @(posedge clk) begin
      if (output_discharge === 1'b1)
         disc_seen <= 1'b1;
      if (soft_start_ramp === 1'b1)
         run <= run + 1;
      else if (run != 0) begin
         last_soft <= run;
         run <= 0;
      end
   end

   function automatic logic exp_fault(input logic [3:0] v);
      return v[3] | (v[2] ? v[0] : v[1]);
   endfunction
   function automatic int lead(input logic otg, input logic auto_m);
      return otg ? LD : DEB + (auto_m ? BBM : LD);
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // One APB transfer, entered just after an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Counts cycles until the chosen switch conducts
   task automatic wait_sw(input logic otg, input logic auto_m);
      int lo;
      lo = lead(otg, auto_m);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((otg ? switch_otg : switch_forward) !== 1'b1 && n < 300);
      `CHK("delay", 1'b1, n >= lo && n <= lo + 20)
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, en_req, otg_req} = '0;
      {wired_power_input_ok, ovp_high_trip, ovp_low_trip, over_temp} = '0;
      {overvoltage_threshold_select, disc_seen, run, last_soft} = '0;
      {bad_count, cmp_count} = '0;
      output_ok = 1'b1;
      slave = 1'b1;
      seed = 84104;
      reset = 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      apb(1'b0, CTRL_ADDR, 32'h0);
      `CHK("ctrl reset", {30'h0, CTRL_RESET}, rd)
      `CHK("ctrl resp", 1'b0, rerr)
      for (int i = 0; i < 3; i++) begin
         wv = $random(seed);
         apb(1'b1, CTRL_ADDR, wv);
         apb(1'b0, CTRL_ADDR, 32'h0);
         `CHK("ctrl", {30'h0, wv[1:0]}, rd)
      end
      apb(1'b1, 8'h08, 32'hffffffff);
      `CHK("unmapped err", 1'b1, rerr)
      apb(1'b0, 8'h08, 32'h0);
      `CHK("unmapped rd", 32'h0, rd)
      apb(1'b1, CTRL_ADDR, 32'h0);
      // Slave forward: debounce, delay, ramp
      disc_seen <= 1'b0;
      en_req <= 1'b1;
      wired_power_input_ok <= 1'b1;
      wait_sw(1'b0, 1'b0);
      repeat (SOFT + 4) @(posedge clk);
      `CHK("ramp", SOFT, last_soft)
      `CHK("no bbm", 1'b0, disc_seen)
      `CHK("no otg", 1'b0, switch_otg)
      apb(1'b0, STATUS_ADDR, 32'h0);
      `CHK("state", ST_ON, rd[2:0])
      `CHK("in ok", 1'b1, rd[ST_INOK_BIT])
      `CHK("cg low", 1'b0, charger_good_output_oe_n)
      en_req <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK("off", 1'b0, switch_forward)
      // Slave reverse conduction
      wired_power_input_ok <= 1'b0;
      repeat (10) @(posedge clk);
      en_req <= 1'b1;
      wait_sw(1'b1, 1'b0);
      `CHK("cg hiz", 1'b1, charger_good_output_oe_n)
      // Software hold drops reverse conduction, release restarts it
      apb(1'b1, CTRL_ADDR, 32'h2);
      repeat (3) @(posedge clk);
      `CHK("hold", 1'b0, switch_otg)
      apb(1'b1, CTRL_ADDR, 32'h0);
      repeat (LD + SOFT + 10) @(posedge clk);
      // Fault cases by threshold selection
      for (int c = 0; c < 5; c++) begin
         {over_temp, overvoltage_threshold_select, ovp_high_trip,
            ovp_low_trip} <= FT[c];
         repeat (10) @(posedge clk);
         `CHK("fault", exp_fault(FT[c]), fault)
         `CHK("otg", ~exp_fault(FT[c]), switch_otg)
         {over_temp, overvoltage_threshold_select, ovp_high_trip,
            ovp_low_trip} <= 4'h0;
         repeat (LD + SOFT + 20) @(posedge clk);
      end
      // Random enable toggling
      for (int k = 0; k < 6; k++) begin
         en_req <= $random(seed);
         repeat (($random(seed) & 31) + 1) @(posedge clk);
      end
      en_req <= 1'b0;
      repeat (10) @(posedge clk);
      // Autonomous: flag high, fault blocks, then reverse
      apb(1'b1, CTRL_ADDR, 32'h1);
      slave <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK("flag high", 1'b1, flag_oe_n)
      `CHK("cg hiz", 1'b1, charger_good_output_oe_n)
      over_temp <= 1'b1;
      otg_req <= 1'b1;
      repeat (LD + 20) @(posedge clk);
      `CHK("ignored", 1'b0, switch_otg)
      over_temp <= 1'b0;
      otg_req <= 1'b0;
      repeat (10) @(posedge clk);
      otg_req <= 1'b1;
      wait_sw(1'b1, 1'b1);
      repeat (SOFT + 4) @(posedge clk);
      `CHK("ramp", SOFT, last_soft)
      otg_req <= 1'b0;
      repeat (10) @(posedge clk);
      // Autonomous forward with break-before-make
      disc_seen <= 1'b0;
      wired_power_input_ok <= 1'b1;
      wait_sw(1'b0, 1'b1);
      `CHK("discharge", 1'b1, disc_seen)
      `CHK("flag low", 1'b0, flag_oe_n)
      `CHK("rx off", 1'b1, receiver_dc_enable_oe_n)
      `CHK("od low", 3'h0, od)
      repeat (SOFT + 4) @(posedge clk);
      disc_seen <= 1'b0;
      wired_power_input_ok <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK("removed", 1'b0, switch_forward)
      `CHK("no bbm", 1'b0, disc_seen)
      finish_test();
   end
endmodule
